// ==== verilog/matrix_cfg_pkg.sv ====
package matrix_cfg_pkg;
    // Priority field width and levels
    localparam int PRIO_W = 2;
    localparam logic [1:0] LVL_NORMAL = 2'h0;
    localparam logic [1:0] LVL_BW_SENS = 2'h1;
    localparam logic [1:0] LVL_LAT_SENS = 2'h2;
    localparam logic [1:0] LVL_LAT_CRIT = 2'h3;
    // Pools that use round-robin inside
    localparam logic [1:0] POOL_LOWEST = 2'h0;
    localparam logic [1:0] POOL_HIGHEST = 2'h3;
    // Default geometry
    localparam int NUM_MASTERS = 8;
    localparam int NUM_CS = 4;
    localparam int NUM_SYSIO = 8;
    localparam int SRC_W = 8;
    // Key that unlocks the protection mode register
    localparam logic [23:0] PROTECT_KEY = 24'h4d4154;
    // Protection mode register layout
    localparam int KEY_LSB = 8;
    localparam int PEN_BIT = 0;
    // Dynamic gating bit positions
    localparam int GATE_MATRIX = 0;
    localparam int GATE_BRIDGE = 1;
    localparam int GATE_FLASH = 2;
    localparam logic [2:0] GATE_RESET = 3'h0;
endpackage : matrix_cfg_pkg

// ==== verilog/slave_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
// One slave arbiter: fixed priority between pools, round-robin in the
// highest and lowest pools, grant held until the transfer ends.
module slave_arbiter #(
    parameter int NM = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [NM-1:0] req,
    input wire logic [2*NM-1:0] prio,
    input wire logic xfer_done,
    output logic [NM-1:0] grant,
    output logic [1:0] grant_prio,
    output logic busy
);
    localparam int IW = (NM > 1) ? $clog2(NM) : 1;

    // Refused at elaboration: the owner index is at most four bits wide
    if (NM < 2 || NM > 16) begin : g_bad_nm
        $error("slave_arbiter: NM must be 2..16");
    end

    // Whole state as one struct
    typedef struct packed {
        logic busy;
        logic [IW-1:0] owner;
        logic [IW-1:0] last;
        logic [1:0] lvl;
    } arb_t;

    arb_t st;
    arb_t next_st;
    logic [1:0] best; // Highest requested level
    logic [IW-1:0] pick; // Chosen master
    logic found;
    logic [IW-1:0] idx;

    // Master priority field for one master
    function automatic logic [1:0] prio_of(input logic [2*NM-1:0] p,
                                            input int m);
        prio_of = p[2*m +: 2];
    endfunction : prio_of

    // Decision logic
    always_comb begin
        next_st = st;
        best = 2'h0;
        pick = '0;
        found = 1'b0;
        idx = '0;
        // Highest level among requesters wins across pools
        for (int m = 0; m < NM; m++) begin
            if (req[m] && prio_of(prio, m) > best) begin
                best = prio_of(prio, m); // see R01 see R03 see R05
            end
        end
        if (best == matrix_cfg_pkg::POOL_HIGHEST ||
            best == matrix_cfg_pkg::POOL_LOWEST) begin
            // Round-robin by rising master number after the last owner
            for (int k = 1; k <= NM; k++) begin
                idx = IW'((int'(st.last) + k) % NM);
                if (!found && req[idx] &&
                    prio_of(prio, int'(idx)) == best) begin
                    pick = idx; // see R06
                    found = 1'b1;
                end
            end
        end else begin
            // Intermediate pools: lowest master number breaks ties
            for (int m = NM - 1; m >= 0; m--) begin
                if (req[m] && prio_of(prio, m) == best) begin
                    pick = IW'(m); // see R02 see R04
                    found = 1'b1;
                end
            end
        end
        if (st.busy) begin
            // Grant stays until the transfer completes
            if (xfer_done) begin
                next_st.busy = 1'b0; // see R18
            end
        end else if (found) begin
            next_st.busy = 1'b1;
            next_st.owner = pick;
            next_st.last = pick;
            next_st.lvl = best;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // One-hot grant from the held owner
    always_comb begin
        grant = '0;
        if (st.busy) begin
            grant[st.owner] = 1'b1; // see R18
        end
    end
    assign grant_prio = st.lvl; // see R08
    assign busy = st.busy;

    chk_grant_onehot: // see R18
        assert property (@(posedge mclk) disable iff (srst)
        $onehot0(grant)) else $error("more than one grant");
    chk_grant_held: // see R18
        assert property (@(posedge mclk) disable iff (srst)
        busy && !xfer_done |=> $stable(grant) && busy)
        else $error("grant dropped early");
    chk_grant_top: // see R03
        assert property (@(posedge mclk) disable iff (srst)
        !busy && |req |=> busy && grant_prio == $past(best))
        else $error("grant not to top level");
endmodule : slave_arbiter
`default_nettype wire

// ==== verilog/bus_matrix_arbiter_config.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: Fixed priority between different priority pools.
// R02: Intermediate pools also use fixed priority.
// R03: Highest programmed priority number wins.
// R04: Equal priority broken by master number.
// R05: Priority from per-master fields, two registers.
// R06: Highest/lowest pools use round-robin, rising number.
// R07: Four levels: normal, bandwidth, latency, critical.
// R08: Forward request priority to SRAM ports.
// R09: System I/O select overrides PIO enables; here it switches io_out only and io_oe follows pio_oe.
// R10: Pad modes stay with PIO controller.
// R11: Each chip select assignable to NAND.
// R12: NAND strobes drive on assigned chip selects.
// R13: Three independent clock gating enable bits.
// R14: Protect enable blocks protected register writes.
// R15: Blocked write sets violation flag.
// R16: Violation records target register.
// R17: Keyed mode write clears violation flag.
// R18: One grant, held until transfer completes.
module bus_matrix_arbiter_config #(
    parameter int NM = matrix_cfg_pkg::NUM_MASTERS,
    parameter int NS = 4,
    parameter int NCS = matrix_cfg_pkg::NUM_CS,
    parameter int NIO = matrix_cfg_pkg::NUM_SYSIO
) (
    input wire logic mclk,
    input wire logic srst,
    // Requests per slave, flattened slave-major
    input wire logic [NS*NM-1:0] slave_req,
    input wire logic [NS-1:0] slave_done,
    output logic [NS*NM-1:0] slave_grant,
    // Priority level forwarded to each SRAM port slave
    output logic [2*NS-1:0] sram_req_prio,
    // Configuration write port
    input wire logic [NS-1:0] prio_a_wr,
    input wire logic [NS-1:0] prio_b_wr,
    input wire logic [NM-1:0] prio_wdata,
    input wire logic master_cfg_wr,
    input wire logic sysio_wr,
    input wire logic [NIO-1:0] sysio_wdata,
    input wire logic nand_cs_wr,
    input wire logic [NCS-1:0] nand_cs_wdata,
    input wire logic gating_wr,
    input wire logic [2:0] gating_wdata,
    input wire logic protect_mode_wr,
    input wire logic [31:0] protect_mode_wdata,
    // System I/O lines
    input wire logic [NIO-1:0] sys_func_out,
    input wire logic [NIO-1:0] pio_out,
    input wire logic [NIO-1:0] pio_oe,
    input wire logic [NIO-1:0] pio_pad_mode,
    output logic [NIO-1:0] io_out,
    output logic [NIO-1:0] io_oe,
    output logic [NIO-1:0] io_pad_mode,
    // Static memory strobes
    input wire logic [NCS-1:0] static_chip_select_line,
    input wire logic smc_rd,
    input wire logic smc_wr,
    output logic nand_output_strobe,
    output logic nand_write_strobe,
    // Status
    output logic matrix_gate_en,
    output logic bridge_gate_en,
    output logic flash_ctrl_gate_en,
    output logic protect_enable,
    output logic protect_violation_flag,
    output logic [matrix_cfg_pkg::SRC_W-1:0] violation_source,
    output logic [NIO-1:0] system_io_select,
    output logic [NCS-1:0] nand_chip_select_assign,
    output logic [NM*2*NS-1:0] master_priority_field,
    output logic [NM-1:0] master_config
);
    localparam int SRC_W = matrix_cfg_pkg::SRC_W;
    localparam int MW = 2 * NM;

    // Refuse geometry the logic cannot serve: the violation source keeps
    // seven bits for the slave index and one code for master config
    if (NM < 2 || NM > 16 || NS < 1 || NS > 64 ||
        NCS < 1 || NIO < 1) begin : g_bad_geom
        $error("bus_matrix_arbiter_config: bad geometry");
    end

    // All configuration state as one struct
    typedef struct packed {
        logic [NS*MW-1:0] prio;
        logic [NM-1:0] mcfg;
        logic [NIO-1:0] sysio;
        logic [NCS-1:0] ncs;
        logic [2:0] gate;
        logic pen;
        logic viol;
        logic [SRC_W-1:0] src;
    } cfg_t;

    cfg_t st;
    cfg_t next_st;
    logic blocked; // A protected write was attempted this cycle
    logic [SRC_W-1:0] blk_src;
    logic key_ok;
    logic [NS-1:0] arb_busy; // Each arbiter holds a grant

    // Source code of a write: bit 7 flags B, low bits the slave
    function automatic logic [SRC_W-1:0] src_code(input int s,
                                                  input logic is_b);
        src_code = {is_b, 7'(s)};
    endfunction : src_code

    assign key_ok = protect_mode_wdata[31:matrix_cfg_pkg::KEY_LSB] ==
                    matrix_cfg_pkg::PROTECT_KEY;

    // Register updates with protection; the lock is the registered enable,
    // so a write in the cycle that arms it still lands
    always_comb begin
        next_st = st;
        blocked = 1'b0;
        blk_src = '0;
        // Priority registers of every slave; when several writes are
        // refused together only the last one in this order is recorded
        for (int s = 0; s < NS; s++) begin
            // Register A holds the low half of masters, B the upper half
            if (prio_a_wr[s]) begin
                if (st.pen) begin
                    blocked = 1'b1; // see R14
                    blk_src = src_code(s, 1'b0);
                end else begin
                    next_st.prio[s*MW +: NM] = prio_wdata; // see R05
                end
            end
            if (prio_b_wr[s]) begin
                if (st.pen) begin
                    blocked = 1'b1; // see R14
                    blk_src = src_code(s, 1'b1);
                end else begin
                    next_st.prio[s*MW+NM +: NM] = prio_wdata; // see R05
                end
            end
        end
        // The master configuration word is locked by the same enable
        if (master_cfg_wr) begin
            if (st.pen) begin
                blocked = 1'b1; // see R14
                blk_src = 8'h7f;
            end else begin
                next_st.mcfg = prio_wdata;
            end
        end
        // Line selection, NAND assignment and gating are never locked
        if (sysio_wr) begin
            next_st.sysio = sysio_wdata;
        end
        if (nand_cs_wr) begin
            next_st.ncs = nand_cs_wdata; // see R11
        end
        if (gating_wr) begin
            next_st.gate = gating_wdata; // see R13
        end
        // Keyed write updates enable and clears the flag
        if (protect_mode_wr && key_ok) begin
            next_st.pen = protect_mode_wdata[matrix_cfg_pkg::PEN_BIT];
            next_st.viol = 1'b0; // see R17
        end
        // A new violation wins over a clear in the same cycle
        if (blocked) begin
            next_st.viol = 1'b1; // see R15
            next_st.src = blk_src; // see R16
        end
    end

    // State register; reset clears every setting and the flag, and gives
    // the gating bits their reset pattern
    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '0;
            st.gate <= matrix_cfg_pkg::GATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // One arbiter per slave
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_arb
            slave_arbiter #(.NM(NM)) u_arb (
                .mclk(mclk),
                .srst(srst),
                .req(slave_req[g*NM +: NM]),
                .prio(st.prio[g*MW +: MW]),
                .xfer_done(slave_done[g]),
                .grant(slave_grant[g*NM +: NM]),
                .grant_prio(sram_req_prio[2*g +: 2]), // see R08 see R07
                .busy(arb_busy[g])
            );
            // A held grant and the busy flag always go together
            chk_busy_grant: // see R18
                assert property (@(posedge mclk)
                disable iff (srst) arb_busy[g] == |slave_grant[g*NM +: NM])
                else $error("grant and busy disagree");
        end
    endgenerate

    // System I/O mux on data only; PIO enables and pad modes pass through
    always_comb begin
        for (int i = 0; i < NIO; i++) begin
            io_out[i] = st.sysio[i] ? sys_func_out[i] : pio_out[i]; // see R09
        end
    end
    assign io_oe = pio_oe; // see R10
    assign io_pad_mode = pio_pad_mode; // see R10

    // NAND strobes for any access on an assigned chip select
    assign nand_output_strobe =
        |(static_chip_select_line & st.ncs) && smc_rd; // see R12
    assign nand_write_strobe =
        |(static_chip_select_line & st.ncs) && smc_wr; // see R12

    assign matrix_gate_en = st.gate[matrix_cfg_pkg::GATE_MATRIX];
    assign bridge_gate_en = st.gate[matrix_cfg_pkg::GATE_BRIDGE];
    assign flash_ctrl_gate_en = st.gate[matrix_cfg_pkg::GATE_FLASH];
    assign protect_enable = st.pen;
    assign protect_violation_flag = st.viol;
    assign violation_source = st.src;
    assign system_io_select = st.sysio;
    assign nand_chip_select_assign = st.ncs;
    assign master_priority_field = st.prio;
    assign master_config = st.mcfg;

    // A refused write to any protectable register
    sequence s_refused_wr;
        protect_enable && (|prio_a_wr || |prio_b_wr || master_cfg_wr);
    endsequence
    // A keyed mode write with no refused write in the same cycle
    sequence s_keyed_clear;
        protect_mode_wr && key_ok && !blocked;
    endsequence

    // Protection: refused writes leave the stored values alone, an allowed write is stored
    chk_blocked_write: // see R14
        assert property (@(posedge mclk) disable iff (srst)
        protect_enable && master_cfg_wr |=> $stable(master_config))
        else $error("protected write got through");
    chk_prio_locked: // see R14
        assert property (@(posedge mclk) disable iff (srst)
        protect_enable && (|prio_a_wr || |prio_b_wr)
        |=> $stable(master_priority_field))
        else $error("protected priority write got through");
    chk_prio_store: // see R05
        assert property (@(posedge mclk) disable iff (srst)
        !protect_enable && prio_a_wr[0]
        |=> master_priority_field[NM-1:0] == $past(prio_wdata))
        else $error("priority write not stored");
    // The flag follows refusals and falls only on a keyed write
    chk_viol_set: // see R15
        assert property (@(posedge mclk) disable iff (srst)
        s_refused_wr |=> protect_violation_flag)
        else $error("violation not flagged");
    chk_viol_src: // see R16
        assert property (@(posedge mclk) disable iff (srst)
        protect_enable && master_cfg_wr |=> violation_source == 8'h7f)
        else $error("violation source not master config");
    chk_viol_hold: // see R17
        assert property (@(posedge mclk) disable iff (srst)
        protect_violation_flag && !protect_mode_wr |=> protect_violation_flag)
        else $error("flag cleared without key");
    chk_key_clear: // see R17
        assert property (@(posedge mclk) disable iff (srst)
        s_keyed_clear |=> !protect_violation_flag)
        else $error("keyed write left the flag set");
    // Gating bits are stored one by one and kept between writes
    chk_gate_write: // see R13
        assert property (@(posedge mclk) disable iff (srst)
        gating_wr |=> bridge_gate_en == $past(gating_wdata[1]))
        else $error("gate bit not stored");
    chk_gate_other: // see R13
        assert property (@(posedge mclk) disable iff (srst)
        gating_wr |=> matrix_gate_en == $past(gating_wdata[0]) &&
        flash_ctrl_gate_en == $past(gating_wdata[2]))
        else $error("gate bits not stored");
    chk_gate_keep: // see R13
        assert property (@(posedge mclk) disable iff (srst)
        !gating_wr |=> $stable({flash_ctrl_gate_en, bridge_gate_en,
        matrix_gate_en}))
        else $error("gate bits changed without a write");
    // Line selection and NAND strobes
    chk_sysio_mux: // see R09
        assert property (@(posedge mclk) disable iff (srst)
        io_out == ((system_io_select & sys_func_out) |
        (~system_io_select & pio_out)))
        else $error("system line not selected");
    chk_nand_we: // see R12
        assert property (@(posedge mclk) disable iff (srst)
        smc_wr && |(static_chip_select_line & nand_chip_select_assign)
        |-> nand_write_strobe) else $error("nand strobe missing");
    chk_nand_oe: // see R12
        assert property (@(posedge mclk) disable iff (srst)
        smc_rd && |(static_chip_select_line & nand_chip_select_assign)
        |-> nand_output_strobe) else $error("nand read strobe missing");
    chk_nand_idle: // see R11
        assert property (@(posedge mclk) disable iff (srst)
        !(|(static_chip_select_line & nand_chip_select_assign))
        |-> !nand_output_strobe && !nand_write_strobe)
        else $error("nand strobe on unassigned select");
endmodule : bus_matrix_arbiter_config
`default_nettype wire

// ==== verif/master_side.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus masters on the request side: a posted request stays up until its
// transfer ends, and the end of each transfer is signalled after hold+1 granted cycles
module master_side #(
    parameter int NS = 4,
    parameter int NM = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [NS*NM-1:0] post,
    input wire logic [NS*NM-1:0] slave_grant,
    input wire logic [7:0] hold,
    output logic [NS*NM-1:0] slave_req,
    output logic [NS-1:0] slave_done
);
    logic [7:0] cnt [NS]; // Cycles spent in the running transfer
    // Request drops only when served, never on a whim of the master
    always_ff @(posedge mclk) begin
        if (srst) begin
            slave_req <= '0;
            slave_done <= '0;
            for (int s = 0; s < NS; s++) cnt[s] <= 8'h00;
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (slave_done[s]) begin
                    // Done lasts one cycle only
                    slave_done[s] <= 1'b0;
                    cnt[s] <= 8'h00;
                    slave_req[s*NM +: NM] <= slave_req[s*NM +: NM] |
                        post[s*NM +: NM];
                end else if (|slave_grant[s*NM +: NM] && cnt[s] == hold) begin
                    // Transfer ends: retire the served master
                    slave_done[s] <= 1'b1;
                    slave_req[s*NM +: NM] <= (slave_req[s*NM +: NM] |
                        post[s*NM +: NM]) & ~slave_grant[s*NM +: NM];
                end else begin
                    if (|slave_grant[s*NM +: NM]) cnt[s] <= cnt[s] + 8'h01;
                    slave_req[s*NM +: NM] <= slave_req[s*NM +: NM] |
                        post[s*NM +: NM];
                end
            end
        end
    end
endmodule : master_side
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0, srst = 1'b1;
    logic [31:0] slave_req, slave_grant, post = '0;
    logic [3:0] slave_done, prio_a_wr = '0, prio_b_wr = '0;
    logic [7:0] sram_req_prio, hold = 8'h02, prio_wdata = '0;
    logic master_cfg_wr = 0, sysio_wr = 0, nand_cs_wr = 0, gating_wr = 0;
    logic protect_mode_wr = 0, smc_rd = 0, smc_wr = 0;
    logic [7:0] sysio_wdata = '0, sys_func_out = '0, pio_out = '0;
    logic [7:0] pio_oe = '0, pio_pad_mode = '0, io_out, io_oe, io_pad_mode;
    logic [3:0] nand_cs_wdata = '0, static_chip_select_line = '0;
    logic [2:0] gating_wdata = '0;
    logic [31:0] protect_mode_wdata = '0;
    logic nand_output_strobe, nand_write_strobe, matrix_gate_en;
    logic bridge_gate_en, flash_ctrl_gate_en, protect_enable;
    logic protect_violation_flag;
    logic [7:0] violation_source, system_io_select, master_config;
    logic [3:0] nand_chip_select_assign;
    logic [63:0] master_priority_field;
    int errors = 0, n_checks = 0, cyc = 0, seed = 32'he31a;
    // Levels of masters 0..7 for slave 0; 0, 2 and 5 share the top pool
    logic [1:0] lv [8] = '{2'h3, 2'h1, 2'h3, 2'h2, 2'h1, 2'h3, 2'h0, 2'h1};
    logic [7:0] pa, pb, r, rem;
    int w; // Master expected to win next

    bus_matrix_arbiter_config i_bus_matrix_arbiter_config (.mclk, .srst,
        .slave_req, .slave_done, .slave_grant, .sram_req_prio, .prio_a_wr,
        .prio_b_wr, .prio_wdata, .master_cfg_wr, .sysio_wr, .sysio_wdata,
        .nand_cs_wr, .nand_cs_wdata, .gating_wr, .gating_wdata,
        .protect_mode_wr, .protect_mode_wdata, .sys_func_out, .pio_out,
        .pio_oe, .pio_pad_mode, .io_out, .io_oe, .io_pad_mode,
        .static_chip_select_line, .smc_rd, .smc_wr, .nand_output_strobe,
        .nand_write_strobe, .matrix_gate_en, .bridge_gate_en,
        .flash_ctrl_gate_en, .protect_enable, .protect_violation_flag,
        .violation_source, .system_io_select, .nand_chip_select_assign,
        .master_priority_field, .master_config);
    master_side i_master_side (.mclk, .srst, .post, .slave_grant, .hold,
        .slave_req, .slave_done);

    // 10 MHz clock
    initial forever #50 mclk = ~mclk;
    // Hang guard: far above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk_val

    // Wait for the slave 0 grant, compare it, then let the transfer end
    task automatic chk_grant(input logic [7:0] exp, input logic [1:0] l);
        int t;
        t = 0;
        while (slave_grant[7:0] === 8'h00 && t < 200) begin
            @(negedge mclk);
            t++;
        end
        n_checks++;
        if (slave_grant[7:0] !== exp) begin
            errors++;
            $display("wrong value at %0t: grant %h", $time, slave_grant[7:0]);
        end
        @(negedge mclk);
        chk_val(sram_req_prio[1:0], l);
        while (slave_grant[7:0] !== 8'h00 && t < 400) begin
            @(negedge mclk);
            t++;
        end
    endtask : chk_grant

    // Write strobe k: 0-3 reg A, 4-7 reg B, 8 master cfg, 9 system I/O,
    // 10 NAND assign, 11 gating, 12 protection mode
    task automatic wr(input int k, input logic [31:0] d);
        @(negedge mclk);
        {prio_wdata, sysio_wdata, nand_cs_wdata} = {d[7:0], d[7:0], d[3:0]};
        {gating_wdata, protect_mode_wdata} = {d[2:0], d};
        if (k < 4) prio_a_wr[k] = 1'b1;
        else if (k < 8) prio_b_wr[k-4] = 1'b1;
        else if (k == 8) master_cfg_wr = 1'b1;
        else if (k == 9) sysio_wr = 1'b1;
        else if (k == 10) nand_cs_wr = 1'b1;
        else if (k == 11) gating_wr = 1'b1;
        else protect_mode_wr = 1'b1;
        @(negedge mclk);
        {prio_a_wr, prio_b_wr, master_cfg_wr, sysio_wr} = '0;
        {nand_cs_wr, gating_wr, protect_mode_wr} = '0;
    endtask : wr

    // Post requests on slave 0 with a random transfer length
    task automatic send(input logic [7:0] m);
        @(negedge mclk);
        post[7:0] = m;
        hold = 8'h02 + 8'($random(seed) & 7);
        @(negedge mclk);
        post = '0;
    endtask : send

    // Fixed-priority winner: highest level, then lowest master number
    function automatic int best(input logic [7:0] m);
        int w;
        w = -1;
        for (int i = 0; i < 8; i++)
            if (m[i] && (w < 0 || lv[i] > lv[w])) w = i;
        return w;
    endfunction : best

    initial begin
        pa = {lv[3], lv[2], lv[1], lv[0]};
        pb = {lv[7], lv[6], lv[5], lv[4]};
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        chk_val({slave_grant, protect_enable, protect_violation_flag}, '0);
        chk_val({flash_ctrl_gate_en, bridge_gate_en, matrix_gate_en}, '0);
        wr(0, pa);
        wr(4, pb);
        chk_val(master_priority_field[15:0], {pb, pa});
        // Mixed pools: one hand-made set, then random sets without the top pool
        for (int n = 0; n < 5; n++) begin
            rem = (n == 0) ? 8'h1a : 8'($random(seed)) & 8'hda;
            send(rem);
            while (rem != 0) begin
                w = best(rem);
                chk_grant(8'h01 << w, lv[w]);
                rem[w] = 1'b0;
            end
        end
        // Lowest pool alone; also leaves the turn pointer at master 6
        send(8'h40);
        chk_grant(8'h40, 2'h0);
        // Top pool: master 0 asks again but must wait its turn
        send(8'h25);
        chk_grant(8'h01, 2'h3);
        send(8'h01);
        chk_grant(8'h04, 2'h3);
        chk_grant(8'h20, 2'h3);
        chk_grant(8'h01, 2'h3);
        // System I/O select and NAND chip selects with random pad traffic
        for (int n = 0; n < 6; n++) begin
            r = 8'($random(seed));
            wr(9, r);
            wr(10, ~r);
            {sys_func_out, pio_out, pio_oe} = 24'($random(seed));
            {pio_pad_mode, static_chip_select_line, smc_rd, smc_wr} =
                14'($random(seed));
            #1;
            chk_val(io_out, (r & sys_func_out) | (~r & pio_out));
            chk_val({io_oe, io_pad_mode}, {pio_oe, pio_pad_mode});
            chk_val(nand_chip_select_assign, 4'(~r[3:0]));
            chk_val(system_io_select, r);
            chk_val({nand_output_strobe, nand_write_strobe},
                {2{|(static_chip_select_line & ~r[3:0])}} &
                {smc_rd, smc_wr});
        end
        // Every gating combination
        for (int k = 0; k < 8; k++) begin
            wr(11, k);
            chk_val({flash_ctrl_gate_en, bridge_gate_en, matrix_gate_en},
                k);
        end
        // Protection: refused writes, source, wrong key, keyed clear
        wr(12, {matrix_cfg_pkg::PROTECT_KEY, 8'h01});
        chk_val(protect_enable, 1'b1);
        wr(5, 8'h3c);
        chk_val(master_priority_field[31:16], 16'h0000);
        chk_val({protect_violation_flag, violation_source},
            9'h181);
        wr(8, 8'h55);
        chk_val({master_config, violation_source}, 16'h007f);
        wr(12, {~matrix_cfg_pkg::PROTECT_KEY, 8'h00});
        chk_val({protect_enable, protect_violation_flag}, 2'h3);
        wr(12, {matrix_cfg_pkg::PROTECT_KEY, 8'h00});
        chk_val({protect_enable, protect_violation_flag}, 2'h0);
        wr(8, 8'h55);
        chk_val({master_config, protect_violation_flag}, 9'haa);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
